// ### common/plmbg_pkg.sv
// ---------------------------------------------------------------------------
// Shared constants for the lock monitor and break guard.
// ---------------------------------------------------------------------------
package plmbg_pkg;

  localparam int          ADDR_W          = 4;
  localparam int          DATA_W          = 8;
  localparam int          CNT_W           = 16;

  // Register offsets on the plain register port.
  localparam logic [3:0]  OFS_PLL_CTRL    = 4'h0;
  localparam logic [3:0]  OFS_BW_CTRL     = 4'h1;
  localparam logic [3:0]  OFS_BRK_CTRL    = 4'h2;
  localparam logic [3:0]  OFS_IRQ_STAT    = 4'h3;
  localparam logic [3:0]  OFS_IRQ_MASK    = 4'h4;

  // Field positions.
  localparam int          BIT_PLL_IE      = 7;
  localparam int          BIT_PLL_EVT     = 6;
  localparam int          BIT_PLL_ON      = 5;
  localparam int          BIT_AUTO        = 7;
  localparam int          BIT_SETTLED     = 6;
  localparam int          BIT_TRACKING    = 5;
  localparam int          BIT_BRK_PERMIT  = 7;
  localparam int          IRQ_W           = 3;
  localparam int          IRQ_TRK         = 0;
  localparam int          IRQ_LOCK_IN     = 1;
  localparam int          IRQ_LOCK_OUT    = 2;

  // Values after reset.
  localparam logic [7:0]  RST_PLL_CTRL    = 8'h00;
  localparam logic [7:0]  RST_BW_CTRL     = 8'h00;
  localparam logic        RST_BRK_PERMIT  = 1'b0;
  localparam logic [2:0]  RST_IRQ_MASK    = 3'h0;

  // Reference divider and window lengths, in cycles and reference periods.
  localparam int          REF_DIV_CYCLES  = 8;
  localparam int          N_ACQ_PERIODS   = 32;
  localparam int          N_TRK_PERIODS   = 128;
  localparam int          TOL_TRK_COUNTS  = 2;
  localparam int          TOL_LOCK_COUNTS = 0;

  typedef enum logic [1:0]
  {
    ST_ACQ  = 2'b00,
    ST_TRK  = 2'b01,
    ST_LOCK = 2'b10
  } plmbg_state_t;

  // Next value of a hardware-set, software-cleared flag; set wins over clear.
  function automatic logic flag_next(input logic cur, input logic set,
                                     input logic clr, input logic hold);
    if (hold)
    begin
      flag_next = cur;
    end
    else
    begin
      flag_next = set | (cur & ~clr);
    end
  endfunction : flag_next

endpackage : plmbg_pkg

// ### logic/plmbg_window_judge.sv
`timescale 1ns/1ps

// ---------------------------------------------------------------------------
// Averaging window: counts feedback edges over a run of reference periods.
// ---------------------------------------------------------------------------
module plmbg_window_judge #(
  parameter int CNT_W = 16
) (
  input  wire logic             clk,
  input  wire logic             arst_n,
  input  wire logic             restart,
  input  wire logic             ref_tick,
  input  wire logic             fb_edge,
  input  wire logic [CNT_W-1:0] win_len,
  input  wire logic [CNT_W-1:0] tol,
  output logic                  pass,
  output logic                  fail
);

  logic [CNT_W-1:0] ref_cnt_ff;
  logic [CNT_W-1:0] fb_cnt_ff;
  logic [CNT_W-1:0] fb_total;
  logic [CNT_W-1:0] diff;
  logic             win_end;
  logic             in_tol;

  // Only the average over the whole window is judged, so a brief excursion
  // inside a window does not disqualify it by itself.
  assign fb_total = fb_cnt_ff + {{(CNT_W-1){1'b0}}, fb_edge};
  assign diff     = (fb_total >= win_len) ? (fb_total - win_len) : (win_len - fb_total);
  assign in_tol   = (diff <= tol);
  assign win_end  = ref_tick && (ref_cnt_ff == (win_len - {{(CNT_W-1){1'b0}}, 1'b1}));

  // Period and edge counters, both restarted at each window end.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ref_cnt_ff <= '0;
      fb_cnt_ff  <= '0;
    end
    else if (restart || win_end)
    begin
      ref_cnt_ff <= '0;
      fb_cnt_ff  <= '0;
    end
    else
    begin
      if (ref_tick)
      begin
        ref_cnt_ff <= ref_cnt_ff + {{(CNT_W-1){1'b0}}, 1'b1};
      end
      fb_cnt_ff <= fb_total;
    end
  end

  // Verdict pulses, one cycle long, after each complete window.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pass <= 1'b0;
      fail <= 1'b0;
    end
    else
    begin
      pass <= win_end && !restart && in_tol;
      fail <= win_end && !restart && !in_tol;
    end
  end

endmodule : plmbg_window_judge

// ### logic/plmbg_top.sv
`timescale 1ns/1ps

// ---------------------------------------------------------------------------
// Lock monitor and break-state flag guard.
// ---------------------------------------------------------------------------
//
// Contract
// - Break with permit set: software may clear flags as usual.
// - A flag cleared during break stays cleared afterwards.
// - Break with permit clear: the event flag does not change, except that leaving auto mode clears it.
// - Permit resets to 0; control register access in guarded break keeps event flag.
// - Auto mode sets tracking bit when the tracking tolerance is confirmed.
// - Auto mode sets settled flag when the lock tolerance is confirmed.
// - Acquisition ends only after a full qualifying window of reference periods.
// - Lock is declared only after a full qualifying second window.
// - Windows judge the average; a failing window starts another, except in lock, where it drops to tracking.
// - Settled flag reads 0 outside auto mode and is cleared by reset.
// - Tracking bit: 1 tracking, 0 acquisition; read-only in auto; reset 0.
// - Auto mode: each settled change outside guarded break sets the event flag; manual reads 0.
module plmbg_top #(
  parameter int REF_DIV   = plmbg_pkg::REF_DIV_CYCLES,
  parameter int N_ACQ     = plmbg_pkg::N_ACQ_PERIODS,
  parameter int N_TRK     = plmbg_pkg::N_TRK_PERIODS,
  parameter int TOL_TRK   = plmbg_pkg::TOL_TRK_COUNTS,
  parameter int TOL_LOCK  = plmbg_pkg::TOL_LOCK_COUNTS
) (
  input  wire logic                          clk,
  input  wire logic                          arst_n,
  input  wire logic [plmbg_pkg::ADDR_W-1:0]  reg_addr,
  input  wire logic [plmbg_pkg::DATA_W-1:0]  reg_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  output logic      [plmbg_pkg::DATA_W-1:0]  reg_rdata,
  input  wire logic                          break_active,
  input  wire logic                          fb_clk_pin,
  output logic                               irq,
  output logic                               pll_irq
);

  localparam int CW = plmbg_pkg::CNT_W;

  // -------------------------------------------------------------------------
  // Register state and decode
  // -------------------------------------------------------------------------
  logic                          pll_ie_ff;
  logic                          pll_on_ff;
  logic                          pll_event_flag_ff;
  logic                          auto_ff;
  logic                          manual_trk_ff;
  logic                          tracking_ff;
  logic                          settled_ff;
  logic                          break_clear_permit_ff;
  logic [plmbg_pkg::IRQ_W-1:0]   irq_stat_ff;
  logic [plmbg_pkg::IRQ_W-1:0]   irq_mask_ff;
  logic [plmbg_pkg::DATA_W-1:0]  nxt_rdata;
  logic                          wr_ctrl;
  logic                          wr_bw;
  logic                          wr_brk;
  logic                          wr_mask;
  logic                          rd_ctrl;
  logic                          rd_stat;
  logic                          clear_guard;
  logic                          evt_clr;

  assign wr_ctrl = reg_wr && (reg_addr == plmbg_pkg::OFS_PLL_CTRL);
  assign wr_bw   = reg_wr && (reg_addr == plmbg_pkg::OFS_BW_CTRL);
  assign wr_brk  = reg_wr && (reg_addr == plmbg_pkg::OFS_BRK_CTRL);
  assign wr_mask = reg_wr && (reg_addr == plmbg_pkg::OFS_IRQ_MASK);
  assign rd_ctrl = reg_rd && (reg_addr == plmbg_pkg::OFS_PLL_CTRL);
  assign rd_stat = reg_rd && (reg_addr == plmbg_pkg::OFS_IRQ_STAT);

  // Clears are only held off in break when the permit is clear.
  assign clear_guard = break_active && !break_clear_permit_ff;

  // The event flag clears on a read of the control register or a 0 written.
  assign evt_clr = rd_ctrl || (wr_ctrl && !reg_wdata[plmbg_pkg::BIT_PLL_EVT]);

  // -------------------------------------------------------------------------
  // Reference tick and feedback pin
  // -------------------------------------------------------------------------
  logic [CW-1:0] div_cnt_ff;
  logic          ref_tick_ff;
  logic          fb_meta_ff;
  logic          fb_sync_ff;
  logic          fb_prev_ff;
  logic          fb_edge;

  // Divided reference clock as a one-cycle enable.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      div_cnt_ff  <= '0;
      ref_tick_ff <= 1'b0;
    end
    else if (div_cnt_ff == CW'(REF_DIV - 1))
    begin
      div_cnt_ff  <= '0;
      ref_tick_ff <= 1'b1;
    end
    else
    begin
      div_cnt_ff  <= div_cnt_ff + {{(CW-1){1'b0}}, 1'b1};
      ref_tick_ff <= 1'b0;
    end
  end

  // The feedback pin is asynchronous, so it is synchronised before use.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      fb_meta_ff <= 1'b0;
      fb_sync_ff <= 1'b0;
      fb_prev_ff <= 1'b0;
    end
    else
    begin
      fb_meta_ff <= fb_clk_pin;
      fb_sync_ff <= fb_meta_ff;
      fb_prev_ff <= fb_sync_ff;
    end
  end

  assign fb_edge = fb_sync_ff && !fb_prev_ff;

  // -------------------------------------------------------------------------
  // Lock state machine
  // -------------------------------------------------------------------------
  plmbg_pkg::plmbg_state_t state_ff;
  plmbg_pkg::plmbg_state_t nxt_state;
  logic                    run;
  logic                    win_pass;
  logic                    win_fail;
  logic                    restart;
  logic [CW-1:0]           win_len;
  logic [CW-1:0]           win_tol;

  assign run     = auto_ff && pll_on_ff;
  assign restart = !run || (nxt_state != state_ff);

  // Acquisition uses the short window and the wide tolerance.
  assign win_len = (state_ff == plmbg_pkg::ST_ACQ) ? CW'(N_ACQ) : CW'(N_TRK);
  assign win_tol = (state_ff == plmbg_pkg::ST_ACQ) ? CW'(TOL_TRK) : CW'(TOL_LOCK);

  plmbg_window_judge #(
    .CNT_W    (CW)
  ) u_judge (
    .clk      (clk),
    .arst_n   (arst_n),
    .restart  (restart),
    .ref_tick (ref_tick_ff),
    .fb_edge  (fb_edge),
    .win_len  (win_len),
    .tol      (win_tol),
    .pass     (win_pass),
    .fail     (win_fail)
  );

  // Only whole windows move the state while running; a failed window repeats, except in lock, which drops to tracking.
  always_comb
  begin
    nxt_state = state_ff;
    if (!run)
      nxt_state = plmbg_pkg::ST_ACQ;
    else
    begin
      case (state_ff)
        plmbg_pkg::ST_ACQ:
          if (win_pass)
            nxt_state = plmbg_pkg::ST_TRK;
        plmbg_pkg::ST_TRK:
          if (win_pass)
            nxt_state = plmbg_pkg::ST_LOCK;
        plmbg_pkg::ST_LOCK:
          if (win_fail)
            nxt_state = plmbg_pkg::ST_TRK;
        default:
          nxt_state = plmbg_pkg::ST_ACQ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      state_ff <= plmbg_pkg::ST_ACQ;
    else
      state_ff <= nxt_state;
  end

  // -------------------------------------------------------------------------
  // Status bits derived from the state
  // -------------------------------------------------------------------------
  logic nxt_settled;
  logic nxt_tracking;
  logic settled_chg;

  // While running, settled moves in the single cycle after a judged window; stopping the monitor clears it on the next edge.
  assign nxt_settled  = run && (nxt_state == plmbg_pkg::ST_LOCK);
  assign nxt_tracking = run ? (nxt_state != plmbg_pkg::ST_ACQ) : manual_trk_ff;
  assign settled_chg  = auto_ff && (nxt_settled != settled_ff);

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      settled_ff  <= 1'b0;
      tracking_ff <= 1'b0;
    end
    else
    begin
      settled_ff  <= nxt_settled;
      tracking_ff <= nxt_tracking;
    end
  end

  // -------------------------------------------------------------------------
  // Software registers
  // -------------------------------------------------------------------------
  // Control bits; the manual tracking choice is kept while auto mode runs.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pll_ie_ff     <= plmbg_pkg::RST_PLL_CTRL[plmbg_pkg::BIT_PLL_IE];
      pll_on_ff     <= plmbg_pkg::RST_PLL_CTRL[plmbg_pkg::BIT_PLL_ON];
      auto_ff       <= plmbg_pkg::RST_BW_CTRL[plmbg_pkg::BIT_AUTO];
      manual_trk_ff <= plmbg_pkg::RST_BW_CTRL[plmbg_pkg::BIT_TRACKING];
    end
    else
    begin
      if (wr_ctrl)
      begin
        pll_ie_ff <= reg_wdata[plmbg_pkg::BIT_PLL_IE];
        pll_on_ff <= reg_wdata[plmbg_pkg::BIT_PLL_ON];
      end
      if (wr_bw)
      begin
        auto_ff <= reg_wdata[plmbg_pkg::BIT_AUTO];
        if (!auto_ff)
          manual_trk_ff <= reg_wdata[plmbg_pkg::BIT_TRACKING];
      end
    end
  end

  // Break permit bit, clear after reset so flags are guarded by default.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      break_clear_permit_ff <= plmbg_pkg::RST_BRK_PERMIT;
    else if (wr_brk)
      break_clear_permit_ff <= reg_wdata[plmbg_pkg::BIT_BRK_PERMIT];
  end

  // Event flag: held whole while guarded, so neither a control register read or write
  // nor a lock change can alter it, though leaving auto mode clears it; a cleared flag is never restored later.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      pll_event_flag_ff <= 1'b0;
    else if (!auto_ff)
      pll_event_flag_ff <= 1'b0;
    else
      pll_event_flag_ff <= plmbg_pkg::flag_next(pll_event_flag_ff, settled_chg,
                                                evt_clr, clear_guard);
  end

  // Sticky interrupt status, cleared by reading it unless guarded in break.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      irq_stat_ff <= '0;
    else
      for (int i = 0; i < plmbg_pkg::IRQ_W; i++)
        irq_stat_ff[i] <= plmbg_pkg::flag_next(irq_stat_ff[i], 1'b0, rd_stat,
                                               clear_guard)
                          | (i == plmbg_pkg::IRQ_TRK && run && !tracking_ff && nxt_tracking)
                          | (i == plmbg_pkg::IRQ_LOCK_IN  && settled_chg && nxt_settled)
                          | (i == plmbg_pkg::IRQ_LOCK_OUT && settled_chg && !nxt_settled);
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      irq_mask_ff <= plmbg_pkg::RST_IRQ_MASK;
    else if (wr_mask)
      irq_mask_ff <= reg_wdata[plmbg_pkg::IRQ_W-1:0];
  end

  // -------------------------------------------------------------------------
  // Read path and interrupt outputs
  // -------------------------------------------------------------------------
  // Read data is registered and stands for exactly one cycle.
  always_comb
  begin
    nxt_rdata = '0;
    case (reg_addr)
      plmbg_pkg::OFS_PLL_CTRL:
      begin
        nxt_rdata[plmbg_pkg::BIT_PLL_IE]  = pll_ie_ff;
        nxt_rdata[plmbg_pkg::BIT_PLL_EVT] = pll_event_flag_ff;
        nxt_rdata[plmbg_pkg::BIT_PLL_ON]  = pll_on_ff;
      end
      plmbg_pkg::OFS_BW_CTRL:
      begin
        nxt_rdata[plmbg_pkg::BIT_AUTO]     = auto_ff;
        nxt_rdata[plmbg_pkg::BIT_SETTLED]  = settled_ff & auto_ff;
        nxt_rdata[plmbg_pkg::BIT_TRACKING] = tracking_ff;
      end
      plmbg_pkg::OFS_BRK_CTRL:
        nxt_rdata[plmbg_pkg::BIT_BRK_PERMIT] = break_clear_permit_ff;
      plmbg_pkg::OFS_IRQ_STAT:
        nxt_rdata[plmbg_pkg::IRQ_W-1:0] = irq_stat_ff;
      plmbg_pkg::OFS_IRQ_MASK:
        nxt_rdata[plmbg_pkg::IRQ_W-1:0] = irq_mask_ff;
      default:
        nxt_rdata = '0;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      reg_rdata <= '0;
    else
      reg_rdata <= reg_rd ? nxt_rdata : '0;
  end

  // Level interrupts straight from the sticky flags.
  assign irq     = |(irq_stat_ff & irq_mask_ff);
  assign pll_irq = pll_event_flag_ff & pll_ie_ff & auto_ff;

endmodule : plmbg_top

// ### tb/plmbg_top_sva.sv
`timescale 1ns/1ps

// ---------------------------------------------------------------------------
// Port-level checks for the lock monitor and break guard.
// ---------------------------------------------------------------------------
module plmbg_checker (
  input wire logic                         clk,
  input wire logic                         arst_n,
  input wire logic [plmbg_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [plmbg_pkg::DATA_W-1:0] reg_wdata,
  input wire logic                         reg_wr,
  input wire logic                         reg_rd,
  input wire logic [plmbg_pkg::DATA_W-1:0] reg_rdata,
  input wire logic                         break_active,
  input wire logic                         fb_clk_pin,
  input wire logic                         irq,
  input wire logic                         pll_irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  logic       ie_ff;
  logic       on_ff;
  logic       auto_ff;
  logic       permit_ff;
  logic [2:0] mask_ff;

  // Shadows of the writable control bits, so the checks know the mode.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ie_ff     <= 1'b0;
      on_ff     <= 1'b0;
      auto_ff   <= 1'b0;
      permit_ff <= 1'b0;
      mask_ff   <= 3'h0;
    end
    else if (reg_wr)
    begin
      if (reg_addr == plmbg_pkg::OFS_PLL_CTRL)
      begin
        ie_ff <= reg_wdata[plmbg_pkg::BIT_PLL_IE];
        on_ff <= reg_wdata[plmbg_pkg::BIT_PLL_ON];
      end
      if (reg_addr == plmbg_pkg::OFS_BW_CTRL)
      begin
        auto_ff <= reg_wdata[plmbg_pkg::BIT_AUTO];
      end
      if (reg_addr == plmbg_pkg::OFS_BRK_CTRL)
      begin
        permit_ff <= reg_wdata[plmbg_pkg::BIT_BRK_PERMIT];
      end
      if (reg_addr == plmbg_pkg::OFS_IRQ_MASK)
      begin
        mask_ff <= reg_wdata[2:0];
      end
    end
  end

  property p_rdata_idle;
    !reg_rd |=> reg_rdata == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");

  property p_unmapped;
    reg_rd && reg_addr > plmbg_pkg::OFS_IRQ_MASK |=> reg_rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("hole in map read nonzero");

  property p_permit_field;
    reg_rd && reg_addr == plmbg_pkg::OFS_BRK_CTRL |=> reg_rdata == {permit_ff, 7'h00};
  endproperty
  a_permit_field: assert property (p_permit_field) else $error("permit bit wrong");

  property p_ctrl_rw;
    reg_rd && reg_addr == plmbg_pkg::OFS_PLL_CTRL |=>
      reg_rdata[7] == ie_ff && reg_rdata[5] == on_ff;
  endproperty
  a_ctrl_rw: assert property (p_ctrl_rw) else $error("control bits wrong");

  property p_settled_manual;
    reg_rd && reg_addr == plmbg_pkg::OFS_BW_CTRL && !auto_ff |=> !reg_rdata[6];
  endproperty
  a_settled_manual: assert property (p_settled_manual) else $error("settled is set");

  property p_evt_manual;
    reg_rd && reg_addr == plmbg_pkg::OFS_PLL_CTRL && !auto_ff |=> !reg_rdata[6];
  endproperty
  a_evt_manual: assert property (p_evt_manual) else $error("event flag in manual");

  property p_pll_irq_src;
    pll_irq |-> ie_ff && auto_ff;
  endproperty
  a_pll_irq_src: assert property (p_pll_irq_src) else $error("pll_irq not enabled");

  property p_frozen;
    break_active && !permit_ff && !reg_wr |=> $stable(pll_irq);
  endproperty
  a_frozen: assert property (p_frozen) else $error("event flag moved in break");

  property p_irq_mask;
    irq |-> mask_ff != 3'h0;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("irq while all masked");

  c_lock: cover property (reg_rd && reg_addr == plmbg_pkg::OFS_BW_CTRL ##1 reg_rdata[6]);
  c_pll_irq: cover property ($rose(pll_irq));
  c_break: cover property (break_active && !permit_ff && reg_rd);
endmodule : plmbg_checker

bind plmbg_top plmbg_checker plmbg_checker_i (
  .clk          (clk),
  .arst_n       (arst_n),
  .reg_addr     (reg_addr),
  .reg_wdata    (reg_wdata),
  .reg_wr       (reg_wr),
  .reg_rd       (reg_rd),
  .reg_rdata    (reg_rdata),
  .break_active (break_active),
  .fb_clk_pin   (fb_clk_pin),
  .irq          (irq),
  .pll_irq      (pll_irq)
);

// ### tb/plmbg_fb_model.sv
`timescale 1ns/1ps

// ---------------------------------------------------------------------------
// Divided feedback clock, on frequency or at twice the rate.
// ---------------------------------------------------------------------------
module plmbg_fb_model #(
  parameter int PER = 4
) (
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic fast,
  output logic      fb_clk_pin
);
  int cnt_ff;

  // One edge per reference tick when on frequency; doubled, no window can qualify.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cnt_ff <= 0;
    end
    else
    begin
      cnt_ff <= (cnt_ff + 1) % PER;
    end
  end

  assign fb_clk_pin = fast ? cnt_ff[0] : (cnt_ff < PER / 2);
endmodule : plmbg_fb_model

// ### tb/plmbg_top_bench.sv
`timescale 1ns/1ps

// ---------------------------------------------------------------------------
// Bench for the lock monitor and break guard.
// ---------------------------------------------------------------------------
module plmbg_top_bench;
  localparam int         RDIV = 4;
  localparam int         NACQ = 4;
  localparam int         NTRK = 8;
  localparam logic [3:0] A_CT = plmbg_pkg::OFS_PLL_CTRL;
  localparam logic [3:0] A_BW = plmbg_pkg::OFS_BW_CTRL;
  localparam logic [3:0] A_BK = plmbg_pkg::OFS_BRK_CTRL;
  localparam logic [3:0] A_ST = plmbg_pkg::OFS_IRQ_STAT;
  localparam logic [3:0] A_MK = plmbg_pkg::OFS_IRQ_MASK;
  logic       clk = 1'b0;
  logic       arst_n = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic       break_active = 1'b0;
  logic       fast = 1'b0;
  logic       fb_clk_pin;
  logic       irq;
  logic       pll_irq;
  logic [7:0] d;
  int         fails = 0;
  int         check_count = 0;
  int         cyc = 0;
  int         t0;

  plmbg_top #(.REF_DIV(RDIV), .N_ACQ(NACQ), .N_TRK(NTRK), .TOL_TRK(1), .TOL_LOCK(0))
    plmbg_top_i (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
                 .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
                 .break_active(break_active), .fb_clk_pin(fb_clk_pin), .irq(irq),
                 .pll_irq(pll_irq));

  plmbg_fb_model #(.PER(RDIV)) plmbg_fb_model_i (.clk(clk), .arst_n(arst_n), .fast(fast),
                                                 .fb_clk_pin(fb_clk_pin));

  // Clock and a cycle count used to time the monitor's decisions.
  always #12.5 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1; // Lets the write take effect before any pin is compared.
  endtask : wr

  // Data is taken just after the edge that follows the strobe, its only valid cycle.
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd

  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value at %0t: register %h, expected %h", $time, got, exp);
    end
  endtask : chk_reg

  task automatic chk_pin(input logic got, input logic exp);
    #1;
    check_count++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value at %0t: pin %b, expected %b", $time, got, exp);
    end
  endtask : chk_pin

  // Polls a bandwidth bit; the limit is about ten times the expected lock time.
  task automatic poll(input int b, input logic v);
    rd(A_BW);
    for (int n = 0; n < 240 && d[b] !== v; n++) rd(A_BW);
    chk_pin(d[b], v);
  endtask : poll

  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
    begin
      $display("NO MISMATCHES");
    end
    else
    begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : give_verdict

  // Main sequence: reset values, manual mode, lock, break guard, loss of lock.
  initial
  begin
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    for (int a = 0; a < 8; a++)
    begin
      rd(a[3:0]);
      chk_reg(d, 8'h00);
    end
    chk_pin(pll_irq, 1'b0);
    wr(A_BW, 8'h20);
    rd(A_BW);
    chk_reg(d, 8'h20);
    @(posedge clk);
    fast <= 1'b1;
    wr(A_CT, 8'hA0);
    wr(A_BW, 8'h80);
    repeat (5 * NACQ * RDIV) @(posedge clk);
    rd(A_BW);
    chk_reg(d, 8'h80);
    @(posedge clk);
    fast <= 1'b0;
    t0 = cyc;
    poll(plmbg_pkg::BIT_TRACKING, 1'b1);
    chk_pin(cyc - t0 >= NACQ * RDIV, 1'b1);
    t0 = cyc;
    poll(plmbg_pkg::BIT_SETTLED, 1'b1);
    chk_pin(cyc - t0 >= NTRK * RDIV - 4, 1'b1);
    rd(A_BW);
    chk_reg(d, 8'hE0);
    chk_pin(pll_irq, 1'b1);
    chk_pin(irq, 1'b0);
    wr(A_MK, 8'h07);
    chk_pin(irq, 1'b1);
    rd(A_ST);
    chk_reg(d, 8'h03);
    chk_pin(irq, 1'b0);
    @(posedge clk);
    break_active <= 1'b1;
    rd(A_CT);
    chk_reg(d, 8'hE0);
    wr(A_CT, 8'hA0);
    rd(A_CT);
    chk_reg(d, 8'hE0);
    wr(A_BK, 8'h80);
    rd(A_BK);
    chk_reg(d, 8'h80);
    wr(A_CT, 8'hA0);
    rd(A_CT);
    chk_reg(d, 8'hA0);
    @(posedge clk);
    break_active <= 1'b0;
    rd(A_CT);
    chk_reg(d, 8'hA0);
    @(posedge clk);
    fast <= 1'b1;
    poll(plmbg_pkg::BIT_SETTLED, 1'b0);
    chk_pin(pll_irq, 1'b1);
    rd(A_ST);
    chk_reg(d, 8'h04);
    wr(A_BW, 8'h00);
    chk_pin(pll_irq, 1'b0);
    rd(A_CT);
    chk_reg(d, 8'hA0);
    repeat (10 * NTRK * RDIV) @(posedge clk);
    rd(A_BW);
    chk_reg(d, 8'h00);
    give_verdict();
  end

  // Watchdog: the sequence needs well under a thousand cycles.
  initial
  begin
    repeat (4000) @(posedge clk);
    fails++;
    give_verdict();
  end
endmodule : plmbg_top_bench
